// ### verilog/mac_pmove_defines.svh
// Purpose: constants for the multiply/ALU parallel-move decoder
// Assumes: 16-bit instruction word, 36-bit accumulators
// Notes:   included by bare name
`ifndef MAC_PMOVE_DEFINES_SVH
`define MAC_PMOVE_DEFINES_SVH

// ==========================================================
// opcode values of instruction bits 15..11
`define OPC_PTR_ONLY   5'h06
`define OPC_ST_A0      5'h1c
`define OPC_ST_A1      5'h04
`define OPC_LD_X       5'h16
`define OPC_LD_Y       5'h17
`define OPC_LD_XY      5'h1f

// ==========================================================
// field positions
`define FLD_OPC_HI     15
`define FLD_OPC_LO     11
`define FLD_DST        10
`define FLD_SRC        9
`define FLD_F1_HI      8
`define FLD_F1_LO      5
`define FLD_HALF       4
`define FLD_PSEL_HI    3
`define FLD_PSEL_LO    2
`define FLD_PMOD_HI    1
`define FLD_PMOD_LO    0

// ==========================================================
// pointer post-modification codes
`define PMOD_NONE      2'h0
`define PMOD_INC       2'h1
`define PMOD_DEC       2'h2
`define PMOD_STEP      2'h3

// ==========================================================
// reset values and timing
`define ACC_RST        36'h0
`define PROD_RST       32'h0
`define WORD_RST       16'h0
`define FLAGS_RST      3'h0
`define STORE_CYCLES   2
`define MOVE_CYCLES    1

`endif

// ### verilog/mac_pmove_pkg.sv
// Purpose: types for the multiply/ALU parallel-move decoder
// Assumes: constants live in mac_pmove_defines.svh
// Notes:   nothing here is imported; users write the package name
package mac_pmove_pkg;

	typedef logic [35:0] acc_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_OPER = 2'b10
	} state_t;

	typedef enum logic [2:0] {
		FORM_NONE  = 3'b000,
		FORM_PTR   = 3'b001,
		FORM_STORE = 3'b010,
		FORM_LD_X  = 3'b011,
		FORM_LD_Y  = 3'b100,
		FORM_LD_XY = 3'b101
	} form_t;

endpackage

// ### verilog/mac_alu_if.sv
// Purpose: carrier between the sequencer and the arithmetic unit
// Assumes: purely combinational arithmetic side
// Notes:   flags are {negative, zero, guard overflow}
`timescale 1ns/1ps
interface mac_alu_if;
	logic [3:0]           op;
	mac_pmove_pkg::acc_t  src_val;
	logic [15:0]          x;
	logic [15:0]          y;
	logic [31:0]          p;
	mac_pmove_pkg::acc_t  result;
	logic                 acc_we;
	logic                 new_prod;
	logic [31:0]          prod_nxt;
	logic [2:0]           flags;

	modport alu  (input op, src_val, x, y, p,
	              output result, acc_we, new_prod, prod_nxt, flags);
	modport core (output op, src_val, x, y, p,
	              input result, acc_we, new_prod, prod_nxt, flags);
endinterface

// ### verilog/mac_alu.sv
// Purpose: multiply/ALU operation table of the data arithmetic unit
// Assumes: inputs stable for the whole execute cycle
// Notes:   combinational only; the sequencer registers the results
`timescale 1ns/1ps
module mac_alu (
	mac_alu_if.alu bus
);
	mac_pmove_pkg::acc_t ys;
	mac_pmove_pkg::acc_t ps;

	assign ys = {{20{bus.y[15]}}, bus.y};
	assign ps = {{4{bus.p[31]}}, bus.p};
	// operands widened first so the product is formed at full width
	assign bus.prod_nxt = $signed({{16{bus.x[15]}}, bus.x}) *
	                      $signed({{16{bus.y[15]}}, bus.y});
	assign bus.new_prod = (bus.op[3:2] == 2'b00);

	always_comb begin
		bus.acc_we = 1'b1;
		unique case (bus.op)
			4'h0: bus.result = ps;
			4'h1: bus.result = bus.src_val + ps;
			4'h2: begin
				bus.result = ps;
				bus.acc_we = 1'b0;
			end
			4'h3: bus.result = bus.src_val - ps;
			4'h4: bus.result = ps;
			4'h5: bus.result = bus.src_val + ps;
			4'h6: begin
				bus.result = bus.src_val;
				bus.acc_we = 1'b0;
			end
			4'h7: bus.result = bus.src_val - ps;
			4'h8: bus.result = bus.src_val | ys;
			4'h9: bus.result = bus.src_val ^ ys;
			4'ha: begin
				bus.result = bus.src_val & ys;
				bus.acc_we = 1'b0;
			end
			4'hb: begin
				bus.result = bus.src_val - ys;
				bus.acc_we = 1'b0;
			end
			4'hc: bus.result = ys;
			4'hd: bus.result = bus.src_val + ys;
			4'he: bus.result = bus.src_val & ys;
			4'hf: bus.result = bus.src_val - ys;
		endcase
	end

	// negative, zero, value spilled into guard bits
	assign bus.flags = {bus.result[35], bus.result == 36'h0,
	                    ~(&bus.result[35:31] | ~|bus.result[35:31])};
endmodule // mac_alu

// ### verilog/mac_parallel_move_decode.sv
// Purpose: decode and sequencing of multiply/ALU instructions with a parallel move
// Assumes: RAM and table ROM return read data in the cycle the strobe is high
// Notes:   one instruction at a time; acceptance is gated by state ST_IDLE, not by INSTR_READY
//
// Notes on behaviour
// - upper two operand bits pick which of four RAM pointers addresses memory.
// - lower two operand bits post-modify pointer: none, +1, -1, +step.
// - codes 0000-0011 form new product; load, add, multiply only, subtract.
// - codes 0100-0111 no new multiply; copy, add, nop, subtract product.
// - codes 1000-1111 combine source with input two, 1100 loads input two alone; 1010,1011 write nothing.
// - source bit and destination bit each select accumulator zero or one.
// - input two is sign-extended to accumulator width before two-operand ops.
// - all condition flags update from the arithmetic result every instruction.
// - store form writes old accumulator, updates pointer, then does operation.
// - store form takes two cycles; upper five bits pick accumulator.
// - input-one load form: operation, load input one from RAM, update pointer.
// - input-two load form: operation, load input two or low half, update pointer.
// - half-select bit 0 picks low half of input two, 1 high half.
// - dual load: operation, input two from RAM, input one from table ROM.
// - table address advances by one, or by ROM step when half-select set.
// - pointer-only form: operation, read RAM without storing, post-modify pointer.
`timescale 1ns/1ps
`include "mac_pmove_defines.svh"
module mac_parallel_move_decode #(
	parameter int ADDR_W = 16
) (
	input  wire logic               REF_CLK,
	input  wire logic               SYS_RST,
	input  wire logic               INSTR_VALID,
	input  wire logic [15:0]        INSTR,
	input  wire logic [15:0]        RAM_RDATA,
	input  wire logic [15:0]        ROM_RDATA,
	input  wire logic [ADDR_W-1:0]  J_STEP,
	input  wire logic [ADDR_W-1:0]  I_STEP,
	output logic                    INSTR_READY,
	output logic                    INSTR_DONE,
	output logic                    RAM_RE,
	output logic                    RAM_WE,
	output logic [ADDR_W-1:0]       RAM_ADDR,
	output logic [15:0]             RAM_WDATA,
	output logic                    ROM_RE,
	output logic [ADDR_W-1:0]       ROM_ADDR,
	output logic [35:0]             ACC_ZERO,
	output logic [35:0]             ACC_ONE,
	output logic [31:0]             PRODUCT,
	output logic [15:0]             MUL_IN_ONE,
	output logic [31:0]             MUL_IN_TWO,
	output logic [2:0]              FLAGS
);
	// ==========================================================
	// decode helpers
	function automatic mac_pmove_pkg::form_t decode_form(input logic [4:0] opc);
		case (opc)
			`OPC_PTR_ONLY: decode_form = mac_pmove_pkg::FORM_PTR;
			`OPC_ST_A0,
			`OPC_ST_A1:    decode_form = mac_pmove_pkg::FORM_STORE;
			`OPC_LD_X:     decode_form = mac_pmove_pkg::FORM_LD_X;
			`OPC_LD_Y:     decode_form = mac_pmove_pkg::FORM_LD_Y;
			`OPC_LD_XY:    decode_form = mac_pmove_pkg::FORM_LD_XY;
			default:       decode_form = mac_pmove_pkg::FORM_NONE;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] ptr_step(input logic [ADDR_W-1:0] ptr,
	                                               input logic [1:0] mode,
	                                               input logic [ADDR_W-1:0] step);
		case (mode)
			`PMOD_NONE: ptr_step = ptr;
			`PMOD_INC:  ptr_step = ADDR_W'(ptr + 1'b1);
			`PMOD_DEC:  ptr_step = ADDR_W'(ptr - 1'b1);
			default:    ptr_step = ADDR_W'(ptr + step);
		endcase
	endfunction

	// ==========================================================
	// state
	mac_pmove_pkg::state_t  state_r;
	mac_pmove_pkg::state_t  state_nxt;
	mac_pmove_pkg::form_t   form_r;
	mac_pmove_pkg::form_t   in_form;
	logic [15:0]            ir_r;
	logic [ADDR_W-1:0]      ptr_r [4];

	// ==========================================================
	// incoming instruction
	logic                   accept_w;
	logic [ADDR_W-1:0]      in_ptr;
	mac_pmove_pkg::acc_t    in_acc;
	logic [15:0]            store_word;

	assign in_form    = decode_form(INSTR[`FLD_OPC_HI:`FLD_OPC_LO]);
	assign accept_w   = INSTR_VALID & (state_r == mac_pmove_pkg::ST_IDLE) &
	                    (in_form != mac_pmove_pkg::FORM_NONE);
	assign in_ptr     = ptr_r[INSTR[`FLD_PSEL_HI:`FLD_PSEL_LO]];
	assign in_acc     = (INSTR[`FLD_OPC_HI:`FLD_OPC_LO] == `OPC_ST_A0) ?
	                    ACC_ZERO : ACC_ONE;
	assign store_word = INSTR[`FLD_HALF] ? in_acc[31:16] : in_acc[15:0];

	// ==========================================================
	// instruction in flight
	logic                   exec_w;
	logic                   apply_w;
	logic                   half_w;
	logic [ADDR_W-1:0]      cur_ptr;
	logic [ADDR_W-1:0]      ptr_new;
	logic [ADDR_W-1:0]      pt_new;
	mac_alu_if              alu_bus ();

	assign exec_w  = (state_r == mac_pmove_pkg::ST_EXEC);
	assign apply_w = (exec_w & (form_r != mac_pmove_pkg::FORM_STORE)) |
	                 (state_r == mac_pmove_pkg::ST_OPER);
	assign half_w  = ir_r[`FLD_HALF];
	assign cur_ptr = ptr_r[ir_r[`FLD_PSEL_HI:`FLD_PSEL_LO]];
	assign ptr_new = ptr_step(cur_ptr, ir_r[`FLD_PMOD_HI:`FLD_PMOD_LO], J_STEP);
	assign pt_new  = half_w ? ADDR_W'(ROM_ADDR + I_STEP) :
	                          ADDR_W'(ROM_ADDR + 1'b1);

	assign alu_bus.op      = ir_r[`FLD_F1_HI:`FLD_F1_LO];
	assign alu_bus.src_val = ir_r[`FLD_SRC] ? ACC_ONE : ACC_ZERO;
	assign alu_bus.x       = MUL_IN_ONE;
	assign alu_bus.y       = MUL_IN_TWO[31:16];
	assign alu_bus.p       = PRODUCT;

	mac_alu u_alu (
		.bus (alu_bus.alu)
	);

	always_comb begin
		unique case (state_r)
			mac_pmove_pkg::ST_IDLE:
				state_nxt = accept_w ? mac_pmove_pkg::ST_EXEC : mac_pmove_pkg::ST_IDLE;
			mac_pmove_pkg::ST_EXEC:
				state_nxt = (form_r == mac_pmove_pkg::FORM_STORE) ?
				            mac_pmove_pkg::ST_OPER : mac_pmove_pkg::ST_IDLE;
			default:
				state_nxt = mac_pmove_pkg::ST_IDLE;
		endcase
	end

	// ==========================================================
	// sequencer and memory strobes
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state_r     <= mac_pmove_pkg::ST_IDLE;
			form_r      <= mac_pmove_pkg::FORM_NONE;
			ir_r        <= `WORD_RST;
			INSTR_READY <= 1'b0;
			INSTR_DONE  <= 1'b0;
			RAM_RE      <= 1'b0;
			RAM_WE      <= 1'b0;
			RAM_ADDR    <= '0;
			RAM_WDATA   <= `WORD_RST;
			ROM_RE      <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			INSTR_READY <= (state_nxt == mac_pmove_pkg::ST_IDLE);
			INSTR_DONE  <= apply_w;
			RAM_RE      <= accept_w & (in_form != mac_pmove_pkg::FORM_STORE);
			RAM_WE      <= accept_w & (in_form == mac_pmove_pkg::FORM_STORE);
			ROM_RE      <= accept_w & (in_form == mac_pmove_pkg::FORM_LD_XY);
			if (accept_w) begin
				form_r    <= in_form;
				ir_r      <= INSTR;
				RAM_ADDR  <= in_ptr;
				RAM_WDATA <= store_word;
			end
		end
	end

	// ==========================================================
	// pointers and table address
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < 4; i++) begin
				ptr_r[i] <= '0;
			end
			ROM_ADDR <= '0;
		end else if (exec_w) begin
			ptr_r[ir_r[`FLD_PSEL_HI:`FLD_PSEL_LO]] <= ptr_new;
			if (form_r == mac_pmove_pkg::FORM_LD_XY) begin
				ROM_ADDR <= pt_new;
			end
		end
	end

	// ==========================================================
	// arithmetic results and operand loads
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ACC_ZERO   <= `ACC_RST;
			ACC_ONE    <= `ACC_RST;
			PRODUCT    <= `PROD_RST;
			FLAGS      <= `FLAGS_RST;
			MUL_IN_ONE <= `WORD_RST;
			MUL_IN_TWO <= {`WORD_RST, `WORD_RST};
		end else if (apply_w) begin
			FLAGS <= alu_bus.flags;
			if (alu_bus.acc_we & ~ir_r[`FLD_DST]) begin
				ACC_ZERO <= alu_bus.result;
			end
			if (alu_bus.acc_we & ir_r[`FLD_DST]) begin
				ACC_ONE <= alu_bus.result;
			end
			if (alu_bus.new_prod) begin
				PRODUCT <= alu_bus.prod_nxt;
			end
			unique case (form_r)
				mac_pmove_pkg::FORM_LD_X:
					MUL_IN_ONE <= RAM_RDATA;
				mac_pmove_pkg::FORM_LD_Y:
					if (half_w) begin
						MUL_IN_TWO[31:16] <= RAM_RDATA;
					end else begin
						MUL_IN_TWO[15:0] <= RAM_RDATA;
					end
				mac_pmove_pkg::FORM_LD_XY: begin
					MUL_IN_TWO[31:16] <= RAM_RDATA;
					MUL_IN_ONE        <= ROM_RDATA;
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	sequence store_walk_s;
		exec_w ##1 (state_r == mac_pmove_pkg::ST_OPER) ##1
		(state_r == mac_pmove_pkg::ST_IDLE);
	endsequence
	sequence move_walk_s;
		exec_w ##1 (state_r == mac_pmove_pkg::ST_IDLE);
	endsequence

	store_len_a: assert property (accept_w && in_form == mac_pmove_pkg::FORM_STORE
		|=> store_walk_s) else $error("store form not two cycles");
	move_len_a: assert property (accept_w && in_form != mac_pmove_pkg::FORM_STORE
		|=> move_walk_s) else $error("move form not one cycle");
	ptr_pick_a: assert property (accept_w |=> RAM_ADDR == $past(in_ptr))
		else $error("wrong pointer drives address");
	ptr_inc_a: assert property (exec_w && ir_r[1:0] == `PMOD_INC
		|=> cur_ptr == ADDR_W'($past(cur_ptr) + 1'b1)) else $error("pointer not incremented");
	ptr_dec_a: assert property (exec_w && ir_r[1:0] == `PMOD_DEC
		|=> cur_ptr == ADDR_W'($past(cur_ptr) - 1'b1)) else $error("pointer not decremented");
	store_old_a: assert property (accept_w && in_form == mac_pmove_pkg::FORM_STORE
		|=> RAM_WE && RAM_WDATA == $past(store_word) ##1 !RAM_WE)
		else $error("store word or strobe wrong");
	ld_one_a: assert property (exec_w && form_r == mac_pmove_pkg::FORM_LD_X
		|=> MUL_IN_ONE == $past(RAM_RDATA)) else $error("input one not loaded");
	y_low_a: assert property (exec_w && form_r == mac_pmove_pkg::FORM_LD_Y && !half_w
		|=> MUL_IN_TWO[15:0] == $past(RAM_RDATA) && $stable(MUL_IN_TWO[31:16]))
		else $error("low half load wrong");
	pt_step_a: assert property (exec_w && form_r == mac_pmove_pkg::FORM_LD_XY
		|=> ROM_ADDR == $past(pt_new) && MUL_IN_ONE == $past(ROM_RDATA))
		else $error("table step or load wrong");
	no_mult_a: assert property (apply_w && alu_bus.op[3:2] != 2'b00
		|=> $stable(PRODUCT)) else $error("product changed without multiply");
	test_only_a: assert property (apply_w && alu_bus.op[3:1] == 3'b101
		|=> $stable(ACC_ZERO) && $stable(ACC_ONE)) else $error("test op wrote accumulator");
	flag_upd_a: assert property (apply_w |=> FLAGS == $past(alu_bus.flags))
		else $error("flags not updated");
endmodule // mac_parallel_move_decode

// ### tb/tb_top.sv
// Purpose: self-checking bench for the multiply/ALU parallel-move decoder
// Assumes: RAM and table ROM answers are held by the bench for the whole instruction
// Notes:   a reference model tracks every data and address register that the block shows at its ports
`timescale 1ns/1ps
`include "mac_pmove_defines.svh"
module tb_top;
	logic        ref_clk, sys_rst, instr_valid;
	logic [15:0] instr, ram_rdata, rom_rdata, j_step, i_step;
	logic        instr_ready, instr_done, ram_re, ram_we, rom_re;
	logic [15:0] ram_addr, ram_wdata, rom_addr, mul_in_one;
	logic [35:0] acc_zero, acc_one, m_a0, m_a1;
	logic [31:0] product, mul_in_two, m_p, m_y;
	logic [2:0]  flags, m_f;
	logic [15:0] m_x, m_pt, exp_addr, exp_wdata, exp_pt, j_val, i_val;
	logic [15:0] m_ptr [4];
	logic [4:0]  forms [6];
	int          errors, compares;

	mac_parallel_move_decode #(.ADDR_W(16)) uut (
		.REF_CLK     (ref_clk),
		.SYS_RST     (sys_rst),
		.INSTR_VALID (instr_valid),
		.INSTR       (instr),
		.RAM_RDATA   (ram_rdata),
		.ROM_RDATA   (rom_rdata),
		.J_STEP      (j_step),
		.I_STEP      (i_step),
		.INSTR_READY (instr_ready),
		.INSTR_DONE  (instr_done),
		.RAM_RE      (ram_re),
		.RAM_WE      (ram_we),
		.RAM_ADDR    (ram_addr),
		.RAM_WDATA   (ram_wdata),
		.ROM_RE      (rom_re),
		.ROM_ADDR    (rom_addr),
		.ACC_ZERO    (acc_zero),
		.ACC_ONE     (acc_one),
		.PRODUCT     (product),
		.MUL_IN_ONE  (mul_in_one),
		.MUL_IN_TWO  (mul_in_two),
		.FLAGS       (flags)
	);

	always #4 ref_clk = ~ref_clk;

	// ==========================================================
	// compare and verdict
	task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// reference model, updated before each instruction is issued
	task automatic model(input logic [15:0] w, input logic [15:0] rd, input logic [15:0] ro);
		logic [35:0] s, ys, ps, r;
		logic        wr;
		logic [3:0]  op;
		logic [1:0]  md;
		logic [4:0]  opc;
		opc = w[15:11];
		op = w[8:5];
		md = w[1:0];
		s = w[9] ? m_a1 : m_a0;
		ys = {{20{m_y[31]}}, m_y[31:16]};
		ps = {{4{m_p[31]}}, m_p};
		exp_addr = m_ptr[w[3:2]];
		exp_pt = m_pt;
		r = (opc == `OPC_ST_A0) ? m_a0 : m_a1;
		exp_wdata = w[4] ? r[31:16] : r[15:0];
		case (op)
			4'h0, 4'h2, 4'h4: r = ps;
			4'h1, 4'h5: r = s + ps;
			4'h3, 4'h7: r = s - ps;
			4'h6: r = s;
			4'h8: r = s | ys;
			4'h9: r = s ^ ys;
			4'ha, 4'he: r = s & ys;
			4'hc: r = ys;
			4'hd: r = s + ys;
			default: r = s - ys;
		endcase
		wr = !(op == 4'h2 || op == 4'h6 || op == 4'ha || op == 4'hb);
		m_f = {r[35], r == 36'h0, r[35:31] != {5{r[35]}}};
		if (op < 4'h4) m_p = $signed(m_x) * $signed(m_y[31:16]);
		if (wr && w[10]) m_a1 = r;
		if (wr && !w[10]) m_a0 = r;
		m_ptr[w[3:2]] = m_ptr[w[3:2]] + (md == 2'h1 ? 16'h0001 : md == 2'h2 ? 16'hffff :
			md == 2'h3 ? j_val : 16'h0000);
		if (opc == `OPC_LD_X) m_x = rd;
		if (opc == `OPC_LD_Y && w[4]) m_y[31:16] = rd;
		if (opc == `OPC_LD_Y && !w[4]) m_y[15:0] = rd;
		if (opc == `OPC_LD_XY) begin
			m_y[31:16] = rd;
			m_x = ro;
			m_pt = m_pt + (w[4] ? i_val : 16'h0001);
		end
	endtask

	// ==========================================================
	// instruction port access
	task automatic issue(input logic [15:0] w, input logic [15:0] rd, input logic [15:0] ro);
		int   n;
		logic st;
		st = (w[15:11] == `OPC_ST_A0) || (w[15:11] == `OPC_ST_A1);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr       <= w;
		ram_rdata   <= rd;
		rom_rdata   <= ro;
		j_step      <= j_val;
		i_step      <= i_val;
		@(posedge ref_clk);
		// a second request while busy must be ignored
		instr <= w ^ 16'h07ff;
		#1;
		check("ready_busy", instr_ready, 1'b0);
		check("ram_re", ram_re, !st);
		check("ram_we", ram_we, st);
		check("ram_addr", ram_addr, exp_addr);
		if (st) check("ram_wdata", ram_wdata, exp_wdata);
		check("rom_re", rom_re, w[15:11] == `OPC_LD_XY);
		check("rom_addr_pre", rom_addr, exp_pt);
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		#1;
		n = 1;
		while (instr_done !== 1'b1 && n < 6) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (instr_done !== 1'b1) begin
			errors++;
			$display("ERROR instr_done expected 1 seen timeout");
			print_verdict();
		end
		check("cycles", 36'(n), st ? 36'(`STORE_CYCLES) : 36'(`MOVE_CYCLES));
		check("strobes_off", {ram_re, ram_we, rom_re}, 3'h0);
	endtask

	task automatic post_check();
		check("acc_zero", acc_zero, m_a0);
		check("acc_one", acc_one, m_a1);
		check("product", product, m_p);
		check("mul_in_one", mul_in_one, m_x);
		check("mul_in_two", mul_in_two, m_y);
		check("flags", flags, m_f);
		check("rom_addr", rom_addr, m_pt);
		check("ready", instr_ready, 1'b1);
	endtask

	// ==========================================================
	// scenarios
	task automatic do_reset();
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		check("ready_in_reset", instr_ready, 1'b0);
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		m_a0 = 36'h0;
		m_a1 = 36'h0;
		m_p = 32'h0;
		m_y = 32'h0;
		m_x = 16'h0;
		m_pt = 16'h0;
		m_f = 3'h0;
		foreach (m_ptr[i]) m_ptr[i] = 16'h0;
		@(posedge ref_clk);
		#1;
		post_check();
	endtask

	// every form against each op code of the same parity as its form index, every pointer and post-modify code
	task automatic run_batch(input int first, input int last);
		logic [15:0] w, rd, ro;
		for (int k = first; k <= last; k++) begin
			j_val = 16'(k * 3 + 1);
			i_val = 16'(16'hfff0 + k);
			rd = 16'(k * 16'h9e37 + 16'h0015);
			ro = 16'(k * 16'h26f5 + 16'h8000);
			w = {forms[k % 6], k[4], k[5], k[3:0], k[2] ^ k[6], k[1:0] ^ k[3:2], k[6:5] ^ k[1:0]};
			model(w, rd, ro);
			issue(w, rd, ro);
			post_check();
		end
	endtask

	// unknown opcodes are dropped with no side effect
	task automatic refuse_check();
		logic [4:0] bad [3];
		bad = '{5'h00, 5'h05, 5'h1e};
		foreach (bad[i]) begin
			@(posedge ref_clk);
			instr_valid <= 1'b1;
			instr       <= {bad[i], 11'h4a5};
			repeat (3) begin
				@(posedge ref_clk);
				#1;
				check("refused", {instr_done, ram_re, ram_we, rom_re}, 4'h0);
			end
		end
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		#1;
		post_check();
	endtask

	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		instr_valid = 1'b0;
		instr = 16'h0000;
		ram_rdata = 16'h0000;
		rom_rdata = 16'h0000;
		j_step = 16'h0000;
		i_step = 16'h0000;
		errors = 0;
		compares = 0;
		forms = '{`OPC_PTR_ONLY, `OPC_ST_A0, `OPC_LD_X, `OPC_LD_Y, `OPC_LD_XY, `OPC_ST_A1};
		do_reset();
		run_batch(0, 95);
		refuse_check();
		do_reset();
		run_batch(96, 107);
		print_verdict();
	end
endmodule // tb_top
